// ==== verilog/pwg_regs.svh ====
// Register offsets, field positions, reset values and masks of the peripheral write guard
`ifndef PWG_REGS_SVH
`define PWG_REGS_SVH

// Register offsets (byte addresses on the bridge)
`define PWG_PROTECT_SET_OFFSET 8'h04
`define PWG_VIOLATION_OFFSET 8'h08
`define PWG_ADDR_WIDTH 8

// First instance field positions
`define PWG_B0_SERVICE_BIT 1
`define PWG_B0_FLASH_BIT 2
`define PWG_B0_PORT_BIT 3
`define PWG_B0_TRACE_BIT 6

// Third instance field positions
`define PWG_B2_EVENT_BIT 1
`define PWG_B2_SERIAL_LSB 2
`define PWG_B2_SERIAL_MSB 7
`define PWG_B2_TIMER_LSB 8
`define PWG_B2_TIMER_MSB 15
`define PWG_B2_ADC_BIT 16
`define PWG_B2_COMPARATOR_BIT 17
`define PWG_B2_DAC_BIT 18
`define PWG_B2_TOUCH_BIT 19

// Writable masks and reset values per instance
`define PWG_WMASK_0 32'h0000_004E
`define PWG_RESET_0 32'h0000_0002
`define PWG_WMASK_1 32'h0000_0000
`define PWG_RESET_1 32'h0000_0000
`define PWG_WMASK_2 32'h000F_FFFE
`define PWG_RESET_2 32'h0080_0000

// Bus clock enable state after reset per instance
`define PWG_CLK_RESET_EN_0 1'b1
`define PWG_CLK_RESET_EN_1 1'b1
`define PWG_CLK_RESET_EN_2 1'b0

// Violation register fields
`define PWG_VIOL_FLAG_BIT 31
`define PWG_VIOL_WRITE_BIT 30
`define PWG_VIOL_SLOT_MSB 4

`endif

// ==== verilog/pwg_pkg.sv ====
// Types shared by the peripheral write guard modules
`include "pwg_regs.svh"
package pwg_pkg;

  typedef logic [31:0] pwg_word_t;
  typedef logic [4:0] pwg_slot_t;

  // Whole state of the guard top level
  typedef struct packed {
    pwg_word_t protect;
    pwg_word_t rdata;
    logic slverr;
    logic viol_flag;
    logic viol_write;
    pwg_slot_t viol_slot;
  } pwg_state_t;

  // Which register a bus address hits
  typedef enum logic [1:0] {
    PWG_HIT_NONE,
    PWG_HIT_PROTECT,
    PWG_HIT_VIOLATION
  } pwg_hit_t;

  function automatic pwg_word_t pwg_wmask(input int inst);
    if (inst == 0) begin
      pwg_wmask = `PWG_WMASK_0;
    end else if (inst == 1) begin
      pwg_wmask = `PWG_WMASK_1;
    end else begin
      pwg_wmask = `PWG_WMASK_2;
    end
  endfunction

  function automatic pwg_word_t pwg_reset_val(input int inst);
    if (inst == 0) begin
      pwg_reset_val = `PWG_RESET_0;
    end else if (inst == 1) begin
      pwg_reset_val = `PWG_RESET_1;
    end else begin
      pwg_reset_val = `PWG_RESET_2;
    end
  endfunction

endpackage

// ==== verilog/pwg_bus_decode.sv ====
// Address decoder of the guard's register window
`include "pwg_regs.svh"
module pwg_bus_decode
  import pwg_pkg::*;
(
  input wire logic [`PWG_ADDR_WIDTH-1:0] i_addr,
  output pwg_hit_t o_hit
);

  always_comb begin
    if (i_addr == `PWG_PROTECT_SET_OFFSET) begin
      o_hit = PWG_HIT_PROTECT;
    end else if (i_addr == `PWG_VIOLATION_OFFSET) begin
      o_hit = PWG_HIT_VIOLATION;
    end else begin
      o_hit = PWG_HIT_NONE;
    end
  end

endmodule // pwg_bus_decode

// ==== verilog/pwg_access_check.sv ====
// Decides whether one bridge transfer to a guarded peripheral may proceed
module pwg_access_check
  import pwg_pkg::*;
(
  input wire pwg_word_t i_protect,
  input wire logic i_valid,
  input wire logic i_write,
  input wire logic i_debug,
  input wire pwg_slot_t i_slot,
  output logic o_protected,
  output logic o_block
);

  always_comb begin
    o_protected = i_protect[i_slot];
    // Reads are never guarded; debugger writes bypass protection
    o_block = i_valid && i_write && !i_debug && o_protected;
  end

endmodule // pwg_access_check

// ==== verilog/pwg_guard.sv ====
// Peripheral write guard: protect bits, bridge slave and transfer check
// Function
// - One guard instance per bridge blocks writes to its peripherals.
// - Bus clock enabled after reset on instances zero and one, not two.
// - Guard keeps working in sleep whenever its clock runs.
// - Debugger writes ignore protection and always reach the register.
// - Writing zero to a protect bit leaves it unchanged.
// - Writing one to a writable protect bit clears it, or sets it when SET_ON_ONE is set.
// - Third instance: timer units zero to seven at bits 8 to 15.
// - Third instance: serial units zero to five at bits 2 to 7.
// - Third instance: protect register at 0x04, reset 0x00800000.
// - Checks apply to every transfer through the associated bridge.
`include "pwg_regs.svh"
module pwg_guard
  import pwg_pkg::*;
#(
  parameter int INSTANCE = 0,
  parameter bit SET_ON_ONE = 1'b0
)
(
  input wire logic i_clock,
  input wire logic i_nrst,
  // Register access from the bridge
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`PWG_ADDR_WIDTH-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic i_pdebug,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Transfer check toward the guarded peripherals
  input wire logic i_xfer_valid,
  input wire logic i_xfer_write,
  input wire logic i_xfer_debug,
  input wire logic [4:0] i_xfer_slot,
  output logic o_xfer_block,
  output logic o_xfer_protected,
  // Protect vector and clock-gate default toward the system
  output logic [31:0] o_protect,
  output logic o_guard_bus_clock_reset_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants of this instance

  localparam pwg_word_t WMASK = pwg_wmask(INSTANCE);
  localparam pwg_word_t RESET_VAL = pwg_reset_val(INSTANCE);

  localparam pwg_state_t STATE_RESET = '{
    protect: RESET_VAL,
    rdata: 32'h0000_0000,
    slverr: 1'b0,
    viol_flag: 1'b0,
    viol_write: 1'b0,
    viol_slot: 5'h00
  };

  ////////////////////////////////////////////////////////////////////////////
  // State

  pwg_state_t state_q;
  pwg_state_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  pwg_hit_t hit;
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  pwg_word_t wr_bits;
  logic chk_block;
  logic chk_protected;

  pwg_bus_decode u_decode (
    .i_addr(i_paddr),
    .o_hit(hit)
  );

  // Every transfer passing the bridge is checked here
  pwg_access_check u_check (
    .i_protect(state_q.protect),
    .i_valid(i_xfer_valid),
    .i_write(i_xfer_write),
    .i_debug(i_xfer_debug),
    .i_slot(i_xfer_slot),
    .o_protected(chk_protected),
    .o_block(chk_block)
  );

  always_comb begin
    setup_phase = i_psel && !i_penable;
    access_phase = i_psel && i_penable;
    wr_access = access_phase && i_pwrite && !state_q.slverr;
  end

  // Byte strobes limit which protect bits a write may touch
  always_comb begin
    wr_bits = i_pwdata & WMASK;
    for (int b = 0; b < 4; b++) begin
      if (!i_pstrb[b]) begin
        wr_bits[b*8 +: 8] = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_d = state_q;

    // Register read data and error answer are fixed in the setup phase
    if (setup_phase) begin
      state_d.slverr = (hit == PWG_HIT_NONE);
      if (hit == PWG_HIT_PROTECT) begin
        state_d.rdata = state_q.protect;
      end else if (hit == PWG_HIT_VIOLATION) begin
        state_d.rdata = 32'h0000_0000;
        state_d.rdata[`PWG_VIOL_FLAG_BIT] = state_q.viol_flag;
        state_d.rdata[`PWG_VIOL_WRITE_BIT] = state_q.viol_write;
        state_d.rdata[`PWG_VIOL_SLOT_MSB:0] = state_q.viol_slot;
      end else begin
        state_d.rdata = 32'h0000_0000;
      end
    end

    // Protect register write; zeros leave bits alone
    if (wr_access && hit == PWG_HIT_PROTECT) begin
      if (SET_ON_ONE) begin
        state_d.protect = state_q.protect | wr_bits;
      end else begin
        state_d.protect = state_q.protect & ~wr_bits;
      end
    end

    // Software clears the violation flag by writing one to it
    if (wr_access && hit == PWG_HIT_VIOLATION && i_pstrb[3]
        && i_pwdata[`PWG_VIOL_FLAG_BIT]) begin
      state_d.viol_flag = 1'b0;
    end

    // A blocked write in the same cycle wins over the clear
    if (chk_block) begin
      state_d.viol_flag = 1'b1;
      state_d.viol_write = i_xfer_write;
      state_d.viol_slot = i_xfer_slot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // No sleep input: the guard runs whenever its clock does
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Debug flag on the register port is accepted but changes nothing here:
  // the guard's own register is never protected
  logic unused_pdebug;

  always_comb begin
    unused_pdebug = i_pdebug;
    o_prdata = state_q.rdata;
    o_pready = access_phase;
    o_pslverr = access_phase && state_q.slverr;
    o_xfer_block = chk_block;
    o_xfer_protected = chk_protected;
    o_protect = state_q.protect;
  end

  // Default enable the clock controller applies to this guard's bus clock
  always_comb begin
    if (INSTANCE == 0) begin
      o_guard_bus_clock_reset_en = `PWG_CLK_RESET_EN_0;
    end else if (INSTANCE == 1) begin
      o_guard_bus_clock_reset_en = `PWG_CLK_RESET_EN_1;
    end else begin
      o_guard_bus_clock_reset_en = `PWG_CLK_RESET_EN_2;
    end
  end

endmodule // pwg_guard

// ==== sim/pwg_guard_properties.sv ====
// Concurrent checks of the peripheral write guard
module pwg_guard_properties #(
  parameter int INSTANCE = 0
)
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic i_xfer_valid,
  input wire logic i_xfer_write,
  input wire logic i_xfer_debug,
  input wire logic [4:0] i_xfer_slot,
  input wire logic o_xfer_block,
  input wire logic [31:0] o_protect,
  input wire logic o_guard_bus_clock_reset_en
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] WM = (INSTANCE == 0) ? 32'h0000_004E :
    (INSTANCE == 1) ? 32'h0000_0000 : 32'h000F_FFFE;
  // Fixed bits outside the writable mask
  localparam logic [31:0] RO = (INSTANCE == 2) ? 32'h0080_0000 : 32'h0000_0000;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////
  sequence s_wr;
    i_psel && !i_penable && i_paddr == 8'h04 ##1 i_psel && i_penable && i_pwrite;
  endsequence
  AST_ZERO: assert property (s_wr ##0 i_pwdata == 32'h0 |=> $stable(o_protect))
    else $error("zero write changed protect");
  AST_CLEAR: assert property (s_wr ##0 i_pstrb == 4'hF |=>
    (o_protect & $past(i_pwdata) & WM) == 32'h0) else $error("one write left bit set");
  AST_NOWR: assert property (!(i_psel && i_penable && i_pwrite) |=> $stable(o_protect))
    else $error("protect changed without write");
  AST_RO: assert property ((o_protect & ~WM) == RO)
    else $error("fixed protect bit wrong");
  AST_BLOCK: assert property (i_xfer_valid && i_xfer_write && !i_xfer_debug &&
    o_protect[i_xfer_slot] |-> o_xfer_block) else $error("write not blocked");
  AST_DEBUG: assert property (i_xfer_debug |-> !o_xfer_block)
    else $error("debug write blocked");
  AST_OPEN: assert property (!o_protect[i_xfer_slot] |-> !o_xfer_block)
    else $error("open slot blocked");
  AST_CLK: assert property (o_guard_bus_clock_reset_en == (INSTANCE != 2))
    else $error("clock default wrong");
endmodule // pwg_guard_properties

bind pwg_guard pwg_guard_properties #(.INSTANCE(INSTANCE)) pwg_guard_properties_inst (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
  .i_xfer_valid(i_xfer_valid), .i_xfer_write(i_xfer_write), .i_xfer_debug(i_xfer_debug),
  .i_xfer_slot(i_xfer_slot), .o_xfer_block(o_xfer_block), .o_protect(o_protect),
  .o_guard_bus_clock_reset_en(o_guard_bus_clock_reset_en));

// ==== sim/pwg_bridge_model.sv ====
// Bridge master model issuing register transfers to the guard
module pwg_bridge_model (
  input wire logic i_clock,
  input wire logic i_pready,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
    o_pstrb = 4'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    o_pstrb <= w ? 4'hF : 4'h0;
    @(posedge i_clock);
    o_penable <= 1'b1;
    // Hold the whole request until ready is seen, whatever the wait count
    @(posedge i_clock);
    while (!i_pready) begin
      @(posedge i_clock);
    end
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released lines must not keep looking valid
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
endmodule // pwg_bridge_model

// ==== sim/tb.sv ====
// Self-checking bench of the peripheral write guard
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, blk, blk2, xprot, xprot2;
  logic pready, pready2, pslverr, pslverr2;
  logic [7:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, prdata2, prot, prot2;
  logic xv = 1'b0, xw = 1'b0, xd = 1'b0;
  logic [4:0] xs = 5'h0;
  logic [31:0] rq[$], rq2[$];
  logic [3:0] bq[$];
  logic [1:0] sq[$];
  int err_count = 0, total_checks = 0, cyc = 0;
  always #2.5 clock = ~clock;
  pwg_guard #(.INSTANCE(0)) pwg_guard_inst (.i_clock(clock), .i_nrst(rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .i_pdebug(1'b0), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_xfer_valid(xv), .i_xfer_write(xw),
    .i_xfer_debug(xd), .i_xfer_slot(xs), .o_xfer_block(blk), .o_xfer_protected(xprot),
    .o_protect(), .o_guard_bus_clock_reset_en());
  // Third bridge's guard shares the register bus and the transfer inputs
  pwg_guard #(.INSTANCE(2)) pwg_guard_inst2 (.i_clock(clock), .i_nrst(rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .i_pdebug(1'b0), .o_prdata(prdata2),
    .o_pready(pready2), .o_pslverr(pslverr2), .i_xfer_valid(xv), .i_xfer_write(xw),
    .i_xfer_debug(xd), .i_xfer_slot(xs), .o_xfer_block(blk2), .o_xfer_protected(xprot2),
    .o_protect(), .o_guard_bus_clock_reset_en());
  pwg_bridge_model pwg_bridge_model_inst (.i_clock(clock), .i_pready(pready), .o_psel(psel),
    .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
    .o_pstrb(pstrb));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    if (psel && penable) begin
      chk("pready", 32'({pready2, pready}), 32'h0000_0003);
      chk("pslverr", 32'({pslverr2, pslverr}), 32'(sq.pop_front()));
    end
    if (psel && penable && !pwrite) begin
      chk("prdata", prdata, rq.pop_front());
      chk("prdata2", prdata2, rq2.pop_front());
    end
    if (xv) chk("block", 32'({blk2, xprot2, blk, xprot}), 32'(bq.pop_front()));
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] e2);
    rq.push_back(e);
    rq2.push_back(e2);
    sq.push_back({2{a != 8'h04 && a != 8'h08}});
    pwg_bridge_model_inst.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    sq.push_back({2{a != 8'h04 && a != 8'h08}});
    pwg_bridge_model_inst.xfer(1'b1, a, d);
    if (a == 8'h04) prot = prot & ~(d & 32'h0000_004E);
    if (a == 8'h04) prot2 = prot2 & ~(d & 32'h000F_FFFE);
  endtask
  task automatic xidle;
    @(posedge clock);
    xv <= 1'b0;
  endtask
  task automatic xf(input logic [4:0] s, input logic w, input logic d);
    @(posedge clock);
    xv <= 1'b1;
    xs <= s;
    xw <= w;
    xd <= d;
    bq.push_back({w && !d && prot2[s], prot2[s], w && !d && prot[s], prot[s]});
  endtask
  // Back-to-back random transfers, then idle
  task automatic xr;
    repeat (20) xf(5'($urandom), 1'($urandom), 1'($urandom));
    xidle();
  endtask
  initial begin
    void'($urandom(55));
    prot = 32'h0000_0002;
    prot2 = 32'h0080_0000;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h04, prot, prot2);
    rd(8'h10, 32'h0, 32'h0);
    $display("test reset done");
    xf(5'd1, 1'b1, 1'b0);
    xf(5'd1, 1'b1, 1'b1);
    xf(5'd1, 1'b0, 1'b0);
    xidle();
    // Record keeps the blocked write; the clear drops only the flag
    rd(8'h08, 32'hC000_0001, 32'h0);
    wr(8'h08, 32'h8000_0000);
    rd(8'h08, 32'h4000_0001, 32'h0);
    xr();
    $display("test block done");
    wr(8'h04, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    wr(8'h04, 32'hFFFF_FFB1);
    rd(8'h04, prot, prot2);
    wr(8'h04, 32'($urandom));
    rd(8'h04, prot, prot2);
    wr(8'h04, 32'h0000_004E);
    rd(8'h04, prot, prot2);
    xr();
    $display("test clear done");
    stop_test();
  end
endmodule // tb
